// file: serdes_test_and_loopback.sv
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module serdes_test_and_loopback (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [9:0]  txWord,
   input  wire logic        rxSerial,
   input  wire logic [11:0] rxAmplitudeMv,
   input  wire logic        factory_test_enable,
   output logic             txSerial,
   output logic             txSerialOe,
   output logic [9:0]       rxWord,
   output logic             rxWordValid,
   output logic             syncPass,
   output logic             signal_loss_status,
   output logic             rbcHalfRate,
   output logic             testMode,
   input  wire logic        test_port_reset_n,
   input  wire logic        tms,
   input  wire logic        tck,
   input  wire logic        tdi,
   output logic             tdo,
   output logic             tdoOe
);
   import serdes_test_pkg::*;

   // All state of the block in one record.
   typedef struct packed {
      logic [31:0] prdata;       // Read data of the bus.
      logic        pready;       // Bus answer.
      logic        pslverr;      // Bus error answer.
      logic [5:0]  ctrl;         // Software control bits.
      logic [3:0]  txIndex;      // Index of the bit now being sent.
      logic [9:0]  txShift;      // Transmit shift register.
      logic [6:0]  genState;     // Pattern generator register.
      logic        txSerial;     // Serial output bit.
      logic        txSerialOe;   // Serial output enable.
      logic [3:0]  rxIndex;      // Index of the bit now being received.
      logic [9:0]  rxShift;      // Receive shift register.
      logic [9:0]  rxWord;       // Last completed receive word.
      logic        rxWordValid;  // Word completion strobe.
      logic [6:0]  chkState;     // Checker reference register.
      logic [2:0]  chkCount;     // Bits taken while seeding.
      logic        errLatched;   // Sticky checker failure.
      logic        syncPass;     // Shared sync/pass output.
      logic        signalLoss;   // Loss status output.
      logic        rbcHalfRate;  // Half-rate byte clock selection.
      logic        testMode;     // Factory test mode output.
      tap_state_e  tapState;     // Scan controller state.
      logic        tckPrev;      // Last sampled test clock.
      logic [1:0]  ir;           // Active instruction.
      logic [1:0]  irShift;      // Instruction shift register.
      logic [31:0] drShift;      // Data shift register.
      logic        tdo;          // Scan data output.
      logic        tdoOe;        // Scan output enable.
   } state_s;

   state_s s;
   state_s next_s;

   // Advances the seven-stage generator by ten bits, first bit in bit 0.
   function automatic logic [16:0] prbs_ten(input logic [6:0] st);
      logic [6:0] g;
      logic [9:0] w;
      g = st;
      w = '0;
      for (int i = 0; i < WORD_BITS; i++) begin
         w[i] = g[6] ^ g[5];
         g    = {g[5:0], g[6] ^ g[5]};
      end
      return {g, w};
   endfunction

   // Tells whether the seven given receive bits form the comma.
   function automatic logic is_comma(input logic [6:0] bits);
      return bits == COMMA_PATTERN;
   endfunction

   // Next state of the scan controller for a given TMS level.
   function automatic tap_state_e tap_next(input tap_state_e st,
                                           input logic m);
      unique case (st)
         TEST_RESET: return m ? TEST_RESET : RUN_IDLE;
         RUN_IDLE:   return m ? SEL_DR : RUN_IDLE;
         SEL_DR:     return m ? SEL_IR : CAP_DR;
         CAP_DR:     return m ? EXIT1_DR : SHIFT_DR;
         SHIFT_DR:   return m ? EXIT1_DR : SHIFT_DR;
         EXIT1_DR:   return m ? UPD_DR : PAUSE_DR;
         PAUSE_DR:   return m ? EXIT2_DR : PAUSE_DR;
         EXIT2_DR:   return m ? UPD_DR : SHIFT_DR;
         UPD_DR:     return m ? SEL_DR : RUN_IDLE;
         SEL_IR:     return m ? TEST_RESET : CAP_IR;
         CAP_IR:     return m ? EXIT1_IR : SHIFT_IR;
         SHIFT_IR:   return m ? EXIT1_IR : SHIFT_IR;
         EXIT1_IR:   return m ? UPD_IR : PAUSE_IR;
         PAUSE_IR:   return m ? EXIT2_IR : PAUSE_IR;
         EXIT2_IR:   return m ? UPD_IR : SHIFT_IR;
         UPD_IR:     return m ? SEL_DR : RUN_IDLE;
      endcase
   endfunction

   // Computes the whole next state from the present one and the inputs.
   always_comb begin
      logic        enable;     // Global power enable.
      logic        loopback;   // Internal loopback selected.
      logic        pattern;    // Pattern test selected.
      logic        align;      // Alignment or latched checking.
      logic        rxBit;      // Bit arriving at the receiver.
      logic        chkErr;     // Checker mismatch on this bit.
      logic [16:0] gen;        // Generator result for a new word.
      logic [9:0]  newWord;    // Word completed by this bit.
      logic        tckRise;    // Test clock rising edge.
      logic        tckFall;    // Test clock falling edge.
      logic        access;     // Bus access phase waiting for answer.
      next_s     = s;
      enable     = s.ctrl[CTRL_GLOBAL_EN];
      loopback   = s.ctrl[CTRL_LOOPBACK];
      pattern    = s.ctrl[CTRL_PATTERN];
      align      = s.ctrl[CTRL_ALIGN];
      chkErr     = 1'b0;
      gen        = prbs_ten(s.genState);
      newWord    = {1'b0, s.rxShift[9:1]};
      tckRise    = tck & ~s.tckPrev;
      tckFall    = ~tck & s.tckPrev;
      access     = psel & penable & ~s.pready;
      // Serial output turns off in loopback or when powered down.
      rxBit      = loopback ? s.txSerial : rxSerial;
      next_s.txSerialOe = enable & ~loopback;

      // Bus slave: answer one cycle into the access phase.
      next_s.pready  = access;
      next_s.pslverr = 1'b0;
      next_s.prdata  = '0;
      if (access) begin
         unique case (paddr)
            CTRL_ADDR: begin
               next_s.prdata[CTRL_BITS-1:0] = s.ctrl;
            end
            STATUS_ADDR: begin
               next_s.prdata[STAT_SIGNAL_LOSS] = s.signalLoss;
               next_s.prdata[STAT_SYNC_PASS]   = s.syncPass;
               next_s.prdata[STAT_ERR_LATCHED] = s.errLatched;
               next_s.prdata[STAT_TEST_MODE]   = s.testMode;
               next_s.prdata[STAT_CHK_SEEDED]  = s.chkCount == CHK_SEED_BITS;
            end
            RX_WORD_ADDR: begin
               next_s.prdata[WORD_BITS-1:0] = s.rxWord;
            end
            default: begin
               next_s.pslverr = 1'b1;   // Unmapped address.
            end
         endcase
      end
      // A write lands at the edge that samples the answer.
      if (psel & penable & s.pready & pwrite & paddr == CTRL_ADDR) begin
         next_s.ctrl = pwdata[CTRL_BITS-1:0];
      end

      // Loss status with hysteresis; the middle band keeps its value.
      if (rxAmplitudeMv > LOSS_HIGH_MV) begin
         next_s.signalLoss = enable;
      end else if (rxAmplitudeMv < LOSS_LOW_MV) begin
         next_s.signalLoss = 1'b0;
      end
      next_s.testMode = factory_test_enable;
      // Byte clock mode only matters outside pattern test.
      next_s.rbcHalfRate = enable & ~pattern
                         & ~s.ctrl[CTRL_RBC_MODE]
                         & ~s.ctrl[CTRL_WIDTH_SEL];

      if (!enable) begin
         // Powered down: every datapath element except the checker reference register parks idle.
         next_s.txIndex     = '0;
         next_s.txShift     = '0;
         next_s.txSerial    = 1'b0;
         next_s.genState    = PRBS_SEED;
         next_s.rxIndex     = '0;
         next_s.rxShift     = '0;
         next_s.rxWordValid = 1'b0;
         next_s.rxWord      = '0;   // Parallel output parks at zero too.
         next_s.chkCount    = '0;
         next_s.errLatched  = 1'b0;
         next_s.syncPass    = 1'b0;
      end else begin
         // Transmit: load a word at index zero, otherwise shift.
         if (s.txIndex == 4'h0) begin
            if (pattern) begin
               next_s.txShift  = gen[9:0] >> 1;
               next_s.txSerial = gen[0];
               next_s.genState = gen[16:10];
            end else begin
               next_s.txShift  = txWord >> 1;
               next_s.txSerial = txWord[0];
            end
         end else begin
            next_s.txSerial = s.txShift[0];
            next_s.txShift  = s.txShift >> 1;
         end
         next_s.txIndex = (s.txIndex == LAST_BIT_INDEX) ? 4'h0
                                                        : s.txIndex + 4'h1;

         // Receive: collect bits, first bit ends up in bit 0.
         next_s.rxShift     = {rxBit, s.rxShift[9:1]};
         newWord            = next_s.rxShift;
         next_s.rxWordValid = s.rxIndex == LAST_BIT_INDEX;
         next_s.rxIndex     = next_s.rxWordValid ? 4'h0 : s.rxIndex + 4'h1;
         if (next_s.rxWordValid) begin
            next_s.rxWord = newWord;
         end
         // Outside pattern test, with alignment selected, a comma realigns the word boundary.
         if (!pattern && align && is_comma(newWord[9:3])) begin
            next_s.rxIndex     = COMMA_LAST_INDEX + 4'h1;
            next_s.rxWordValid = 1'b0;
         end

         if (pattern) begin
            // Checker seeds itself from line bits before comparing.
            if (s.chkCount != CHK_SEED_BITS) begin
               next_s.chkCount = s.chkCount + 3'h1;
            end else begin
               chkErr = rxBit != (s.chkState[6] ^ s.chkState[5]);
            end
            next_s.chkState = {s.chkState[5:0], rxBit};
            // Latched mode holds any failure until pattern test ends.
            next_s.errLatched = align & (s.errLatched | chkErr);
            next_s.syncPass   = ~chkErr & ~next_s.errLatched;
         end else begin
            // Leaving pattern test drops the latch and reseeds.
            next_s.errLatched = 1'b0;
            next_s.chkCount   = '0;
            next_s.genState   = PRBS_SEED;
            if (next_s.rxWordValid) begin
               next_s.syncPass = is_comma(newWord[6:0]);
            end
         end
      end

      // Scan port, stepped on sampled test clock edges.
      next_s.tckPrev = tck;
      if (!test_port_reset_n) begin
         // Held in reset; the test clock is not looked at.
         next_s.tapState = TEST_RESET;
         next_s.ir       = IR_IDCODE;
         next_s.tdoOe    = 1'b0;
         next_s.tdo      = 1'b0;
      end else begin
         if (tckRise) begin
            // Unconnected TMS and TDI are pulled up outside the core.
            next_s.tapState = tap_next(s.tapState, tms);
            unique case (s.tapState)
               TEST_RESET: next_s.ir = IR_IDCODE;
               CAP_DR: next_s.drShift = (s.ir == IR_IDCODE) ? TAP_IDCODE
                                                            : 32'h0000_0000;
               SHIFT_DR: begin
                  if (s.ir == IR_IDCODE) begin
                     next_s.drShift = {tdi, s.drShift[31:1]};
                  end else begin
                     next_s.drShift = {31'h0000_0000, tdi};
                  end
               end
               CAP_IR:   next_s.irShift = 2'h1;
               SHIFT_IR: next_s.irShift = {tdi, s.irShift[1]};
               UPD_IR:   next_s.ir = s.irShift;
               default: begin
               end
            endcase
         end
         // Output changes on the falling edge, as the standard asks.
         if (tckFall) begin
            next_s.tdoOe = (s.tapState == SHIFT_DR)
                         | (s.tapState == SHIFT_IR);
            next_s.tdo   = (s.tapState == SHIFT_IR) ? s.irShift[0]
                                                    : s.drShift[0];
         end
      end
   end

   // Registers the whole state; synchronous active-low reset.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s          <= '0;
         s.ctrl     <= CTRL_RESET;
         s.genState <= PRBS_SEED;
         s.tapState <= TEST_RESET;
         s.ir       <= IR_IDCODE;
      end else begin
         s <= next_s;
      end
   end

   // Every output comes straight from a state flip-flop.
   assign prdata             = s.prdata;
   assign pready             = s.pready;
   assign pslverr            = s.pslverr;
   assign txSerial           = s.txSerial;
   assign txSerialOe         = s.txSerialOe;
   assign rxWord             = s.rxWord;
   assign rxWordValid        = s.rxWordValid;
   assign syncPass           = s.syncPass;
   assign signal_loss_status = s.signalLoss;
   assign rbcHalfRate        = s.rbcHalfRate;
   assign testMode           = s.testMode;
   assign tdo                = s.tdo;
   assign tdoOe              = s.tdoOe;
endmodule

// file: serdes_test_pkg.sv
package serdes_test_pkg;
   // Byte addresses of the APB registers.
   localparam logic [7:0] CTRL_ADDR     = 8'h00;
   localparam logic [7:0] STATUS_ADDR   = 8'h04;
   localparam logic [7:0] RX_WORD_ADDR  = 8'h08;
   // Bit positions in the control register.
   localparam int CTRL_GLOBAL_EN   = 0;
   localparam int CTRL_LOOPBACK    = 1;
   localparam int CTRL_PATTERN     = 2;
   localparam int CTRL_ALIGN       = 3;
   localparam int CTRL_WIDTH_SEL   = 4;
   localparam int CTRL_RBC_MODE    = 5;
   localparam int CTRL_BITS        = 6;
   // Control value after reset: powered up, every test mode off.
   localparam logic [5:0] CTRL_RESET = 6'h01;
   // Bit positions in the status register.
   localparam int STAT_SIGNAL_LOSS = 0;
   localparam int STAT_SYNC_PASS   = 1;
   localparam int STAT_ERR_LATCHED = 2;
   localparam int STAT_TEST_MODE   = 3;
   localparam int STAT_CHK_SEEDED  = 4;
   // Serial word geometry and the comma, newest bit in the high position.
   localparam int WORD_BITS = 10;
   localparam logic [3:0] LAST_BIT_INDEX   = 4'h9;
   localparam logic [3:0] COMMA_LAST_INDEX = 4'h6;
   localparam logic [6:0] COMMA_PATTERN    = 7'h7C;
   // Seven-stage pattern register seed and checker seeding length.
   localparam logic [6:0] PRBS_SEED        = 7'h7F;
   localparam logic [2:0] CHK_SEED_BITS    = 3'h7;
   // Signal amplitude thresholds in millivolts.
   localparam logic [11:0] LOSS_HIGH_MV = 12'h096;
   localparam logic [11:0] LOSS_LOW_MV  = 12'h032;
   // Test access port instruction codes and identity value (arbitrary).
   localparam logic [1:0]  IR_IDCODE  = 2'h1;
   localparam logic [1:0]  IR_BYPASS  = 2'h3;
   localparam logic [31:0] TAP_IDCODE = 32'h1234_5001;
   // Test access port controller states.
   typedef enum logic [3:0] {
      TEST_RESET, RUN_IDLE, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR,
      EXIT2_DR, UPD_DR, SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR,
      EXIT2_IR, UPD_IR
   } tap_state_e;
endpackage

// file: serdes_test_props.sv
`timescale 1ns/1ps
// Watches the pins of the test block and checks their timing relations.
module serdes_test_props (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [11:0] rxAmplitudeMv,
   input wire logic        factory_test_enable,
   input wire logic        txSerialOe,
   input wire logic [9:0]  rxWord,
   input wire logic        rxWordValid,
   input wire logic        syncPass,
   input wire logic        signal_loss_status,
   input wire logic        rbcHalfRate,
   input wire logic        testMode,
   input wire logic        test_port_reset_n,
   input wire logic        tdoOe
);
   import serdes_test_pkg::*;
   logic [5:0] ctl; // Control value rebuilt from completed bus writes.
   logic [3:0] age; // Cycles since the last control write, saturating.
   // Tracks the control register so mode-dependent pins can be judged.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ctl <= CTRL_RESET;
         age <= 4'h0;
      end else if (psel && penable && pready && pwrite
                   && paddr == CTRL_ADDR) begin
         ctl <= pwdata[5:0];
         age <= 4'h0;
      end else if (age != 4'hF) begin
         age <= age + 4'h1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // A setup cycle, then the access edge; the answer follows one wait.
   sequence s_setup;
      psel && !penable;
   endsequence
   // A comma word received in normal mode.
   sequence s_comma;
      ctl[0] && !ctl[2] && age > 4'h1 && rxWordValid
         && rxWord[6:0] == COMMA_PATTERN;
   endsequence
   // A failure seen in latched pattern mode, long after the mode began.
   sequence s_fail;
      ctl[2] && ctl[3] && age == 4'hF && $fell(syncPass);
   endsequence
   property p_apb_wait;
      s_setup |-> ##2 pready;
   endproperty
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   property p_loss_high;
      rxAmplitudeMv > LOSS_HIGH_MV && ctl[0] && age > 4'h1
         |=> signal_loss_status;
   endproperty
   property p_loss_low;
      rxAmplitudeMv < LOSS_LOW_MV |=> !signal_loss_status;
   endproperty
   property p_test_mode;
      ctl[0] && age > 4'h1 |-> testMode == $past(factory_test_enable);
   endproperty
   property p_loop_hiz;
      ctl[1] && age > 4'h1 |-> !txSerialOe;
   endproperty
   property p_idle;
      !ctl[0] && age > 4'h1 |-> !txSerialOe && !rxWordValid && !syncPass;
   endproperty
   property p_rbc;
      age > 4'h1 |-> rbcHalfRate == (ctl[0] && !ctl[2] && !ctl[4]
                                     && !ctl[5]);
   endproperty
   property p_sync_comma;
      s_comma |-> ##[0:2] syncPass;
   endproperty
   property p_latch;
      s_fail |-> !syncPass [*8];
   endproperty
   property p_tap_reset;
      !test_port_reset_n |=> !tdoOe;
   endproperty
   a_apb_wait: assert property (p_apb_wait)
      else $error("bus answer not after one wait state");
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("ready held longer than one cycle");
   a_loss_high: assert property (p_loss_high)
      else $error("loss status low with strong signal");
   a_loss_low: assert property (p_loss_low)
      else $error("loss status high with weak signal");
   a_test_mode: assert property (p_test_mode)
      else $error("test mode does not follow its input");
   a_loop_hiz: assert property (p_loop_hiz)
      else $error("serial output driven in loopback");
   a_idle: assert property (p_idle)
      else $error("activity while powered down");
   a_rbc: assert property (p_rbc)
      else $error("half rate clock mode wrong");
   a_sync_comma: assert property (p_sync_comma)
      else $error("comma word not marked");
   a_latch: assert property (p_latch)
      else $error("latched failure released");
   a_tap_reset: assert property (p_tap_reset)
      else $error("scan output driven in test reset");
endmodule
bind serdes_test_and_loopback serdes_test_props u_props (
   .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
   .rxAmplitudeMv, .factory_test_enable, .txSerialOe, .rxWord,
   .rxWordValid, .syncPass, .signal_loss_status, .rbcHalfRate, .testMode,
   .test_port_reset_n, .tdoOe
);

// file: serial_peer_model.sv
`timescale 1ns/1ps
// Far end of the serial link: echoes the line back one bit late.
module serial_peer_model (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic txSerial,
   input  wire logic txSerialOe,
   input  wire logic flip,
   output logic      rxSerial
);
   // A flip request corrupts one echoed bit; a released line toggles.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rxSerial <= 1'b0;
      end else if (txSerialOe) begin
         rxSerial <= txSerial ^ flip;
      end else begin
         rxSerial <= ~rxSerial;
      end
   end
endmodule

// file: testbench.sv
`timescale 1ns/1ps
// Drives the test block over the bus and pins and checks the results.
module testbench;
   import serdes_test_pkg::*;
   logic         clk = 1'b0;
   logic         rst_b = 1'b0;
   logic         psel = 1'b0;
   logic         penable = 1'b0;
   logic         pwrite = 1'b0;
   logic [7:0]   paddr = 8'h00;
   logic [31:0]  pwdata = 32'h0000_0000;
   logic [9:0]   txWord = 10'h17C; // Comma word, bit 0 sent first.
   logic [11:0]  rxAmplitudeMv = 12'h064; // Middle band, status holds.
   logic         factory_test_enable = 1'b0; // Kept low in use.
   logic         test_port_reset_n = 1'b0; // Grounded if unused.
   logic         tms = 1'b1;
   logic         tck = 1'b0;
   logic         tdi = 1'b1; // Driven high like an open pin.
   logic         flip = 1'b0;
   logic [31:0]  prdata, rdata, idWord;
   logic         pready, pslverr, txSerial, txSerialOe, rxWordValid;
   logic [9:0]   rxWord;
   logic         syncPass, signal_loss_status, rbcHalfRate, testMode;
   logic         tdo, tdoOe, rxSerial, tdoBit, rerr, seen;
   logic [127:0] hist; // Last 128 transmitted bits, newest in bit 0.
   logic [29:0]  r;
   int           mismatches = 0;
   int           cmp_count = 0;
   // Rows: control, word sent, word expected, check word, sync, oe, rbc.
   logic [29:0]  rows [9] = '{
      {6'h09, 10'h17C, 10'h17C, 4'b1111},
      {6'h29, 10'h17C, 10'h17C, 4'b1110},
      {6'h19, 10'h17C, 10'h17C, 4'b1110}, // Width select high.
      {6'h0B, 10'h17C, 10'h17C, 4'b1101},
      {6'h0B, 10'h283, 10'h283, 4'b1001},
      {6'h05, 10'h283, 10'h000, 4'b0110},
      {6'h25, 10'h283, 10'h000, 4'b0110},
      {6'h07, 10'h283, 10'h000, 4'b0100},
      {6'h00, 10'h283, 10'h000, 4'b1000}
   };
   always #2 clk = ~clk;
   // Keeps a history of the serial output for the pattern checks.
   always @(posedge clk) hist <= {hist[126:0], txSerial};
   serdes_test_and_loopback u_dut (
      .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .txWord, .rxSerial, .rxAmplitudeMv,
      .factory_test_enable, .txSerial, .txSerialOe, .rxWord, .rxWordValid,
      .syncPass, .signal_loss_status, .rbcHalfRate, .testMode,
      .test_port_reset_n, .tms, .tck, .tdi, .tdo, .tdoOe
   );
   serial_peer_model u_peer (
      .clk, .rst_b, .txSerial, .txSerialOe, .flip, .rxSerial
   );
   // Prints the verdict and ends the run.
   task automatic report_and_stop;
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: flag %b, expected %b", $time, got, exp);
      end
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: word %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
   endtask
   // One bus transfer; waits for ready, the watchdog bounds the wait.
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      chk_bit(pready, 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic flip_bit;
      flip <= 1'b1;
      @(posedge clk);
      flip <= 1'b0;
   endtask
   // One scan clock; the output is taken just before the rising edge.
   task automatic tck_pulse(input logic m);
      tms <= m;
      cycles(4);
      tdoBit = tdo;
      tck <= 1'b1;
      cycles(4);
      tck <= 1'b0;
   endtask
   initial begin
      #40000;
      mismatches++;
      report_and_stop();
   end
   initial begin
      cycles(10);
      rst_b <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         r = rows[i];
         apb(1'b1, CTRL_ADDR, {26'h0, r[29:24]});
         txWord <= r[23:14];
         cycles(80);
         chk_bit(syncPass, r[2]);
         chk_bit(txSerialOe, r[1]);
         chk_bit(rbcHalfRate, r[0]);
         if (r[3]) begin
            chk_word({22'h0, rxWord}, {22'h0, r[13:4]});
            // The same word must also be readable over the bus.
            apb(1'b0, RX_WORD_ADDR, 32'h0000_0000);
            chk_word(rdata, {22'h0, r[13:4]});
         end
      end
      apb(1'b1, CTRL_ADDR, 32'h0000_0005);
      txWord <= 10'h155;
      cycles(70);
      txWord <= 10'h3E0;
      cycles(80);
      chk_bit(hist[127], hist[0]);
      chk_word(32'($countones(hist[126:0])), 32'h0000_0040);
      flip_bit();
      seen = 1'b0;
      repeat (20) begin
         @(posedge clk);
         if (syncPass === 1'b0) seen = 1'b1;
      end
      chk_bit(seen, 1'b1);
      cycles(30);
      chk_bit(syncPass, 1'b1);
      apb(1'b1, CTRL_ADDR, 32'h0000_000D);
      cycles(40);
      chk_bit(syncPass, 1'b1);
      flip_bit();
      cycles(30);
      chk_bit(syncPass, 1'b0);
      apb(1'b0, STATUS_ADDR, 32'h0000_0000);
      chk_bit(rdata[STAT_ERR_LATCHED], 1'b1);
      chk_bit(rdata[STAT_CHK_SEEDED], 1'b1);
      apb(1'b1, CTRL_ADDR, 32'h0000_0009);
      apb(1'b0, STATUS_ADDR, 32'h0000_0000);
      chk_bit(rdata[STAT_ERR_LATCHED], 1'b0);
      rxAmplitudeMv <= 12'h0C8;
      cycles(3);
      chk_bit(signal_loss_status, 1'b1);
      rxAmplitudeMv <= 12'h064;
      cycles(3);
      chk_bit(signal_loss_status, 1'b1);
      rxAmplitudeMv <= 12'h014;
      cycles(3);
      chk_bit(signal_loss_status, 1'b0);
      factory_test_enable <= 1'b1;
      cycles(3);
      chk_bit(testMode, 1'b1);
      factory_test_enable <= 1'b0;
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk_bit(rerr, 1'b1);
      chk_word(rdata, 32'h0000_0000);
      apb(1'b1, STATUS_ADDR, 32'hFFFF_FFFF);
      chk_bit(rerr, 1'b0);
      repeat (3) tck_pulse(1'b0);
      chk_bit(tdoOe, 1'b0);
      test_port_reset_n <= 1'b1;
      repeat (5) tck_pulse(1'b1);
      tck_pulse(1'b0);
      tck_pulse(1'b1);
      tck_pulse(1'b0);
      tck_pulse(1'b0);
      for (int i = 0; i < 32; i++) begin
         tck_pulse(i == 31);
         idWord[i] = tdoBit;
      end
      chk_word(idWord, TAP_IDCODE);
      rst_b <= 1'b0;
      cycles(10);
      chk_bit(syncPass, 1'b0);
      chk_bit(testMode, 1'b0);
      rst_b <= 1'b1;
      apb(1'b0, CTRL_ADDR, 32'h0000_0000);
      chk_word(rdata, {26'h0, CTRL_RESET});
      report_and_stop();
   end
endmodule
